// *** gpp_change_detect.sv ***
// Change notification: per-pin reference, sticky status and request.
`timescale 1ns/1ps
module gpp_change_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire gpp_pkg::gpp_word_t pin_now,
  input wire gpp_pkg::gpp_word_t pin_raw,
  input wire logic capture,
  input wire gpp_pkg::gpp_word_t enable,
  input wire logic module_on,
  output gpp_pkg::gpp_word_t status,
  output logic change_irq
);
  import gpp_pkg::*;

  gpp_word_t reference;
  wire gpp_word_t diff;
  wire gpp_word_t raw_diff;
  wire gpp_word_t next_status;
  wire gpp_word_t next_reference;

  // Against the reference kept after this edge, so a read clears its report
  assign diff = pin_now ^ next_reference; // [R18]
  // Raw compare needs no clock, so a change still wakes the core in sleep
  assign raw_diff = pin_raw ^ reference; // [R11]
  // A read clears every flag; diff is zero in that cycle
  assign next_status = (capture ? GPP_ZERO_RST : status) | diff; // [R13]
  assign next_reference = capture ? pin_now : reference; // [R18]
  assign change_irq = module_on & |((status | raw_diff) & enable); // [R11] [R12]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference <= GPP_ZERO_RST;
      status <= GPP_ZERO_RST;
    end else begin
      reference <= next_reference;
      status <= next_status;
    end
  end

endmodule : gpp_change_detect

// *** gpp_pad_model.sv ***
// Pads of the port: outside drivers, weak pulls, board pull-up.
`timescale 1ns/1ps
module gpp_pad_model (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire gpp_pkg::gpp_word_t pull_up_en,
  input wire gpp_pkg::gpp_word_t pull_down_en,
  input wire gpp_pkg::gpp_word_t ext_en,
  input wire gpp_pkg::gpp_word_t ext_val,
  output gpp_pkg::gpp_word_t pad
);
  import gpp_pkg::*;
  // Port wins, then outside device; idle pads rest high on the board
  // pull-up that open drain relies on, unless only pull-down is on
  assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
    (pin_oe_n & ~ext_en & (pull_up_en | ~pull_down_en));
endmodule : gpp_pad_model

// *** gpp_pin_drive.sv ***
// Pad drive logic: direction and open-drain control per pin.
`timescale 1ns/1ps
module gpp_pin_drive (
  input wire gpp_pkg::gpp_word_t direction,
  input wire gpp_pkg::gpp_word_t latch,
  input wire gpp_pkg::gpp_word_t open_drain,
  output logic [gpp_pkg::GPP_WIDTH-1:0] pin_out,
  output logic [gpp_pkg::GPP_WIDTH-1:0] pin_oe_n
);
  import gpp_pkg::*;

  wire gpp_word_t drive_on;
  wire gpp_word_t od_release;

  // Open-drain pins float instead of driving a one
  assign od_release = open_drain & latch; // [R5]
  // Direction one means input, driver off
  assign drive_on = ~direction & ~od_release; // [R1]
  // Open-drain pins only ever pull low
  assign pin_out = latch & ~open_drain; // [R5]
  assign pin_oe_n = ~drive_on; // [R1]

endmodule : gpp_pin_drive

// *** gpp_pkg.sv ***
// Constants, codes and helpers shared by the general purpose port.
package gpp_pkg;

  localparam int GPP_WIDTH = 16;

  typedef logic [GPP_WIDTH-1:0] gpp_word_t;

  // Reset values
  localparam gpp_word_t GPP_DIR_RST = 16'hFFFF;
  localparam gpp_word_t GPP_ANSEL_RST = 16'hFFFF;
  localparam gpp_word_t GPP_ZERO_RST = 16'h0000;

  // Register select codes on the access port
  localparam logic [3:0] GPP_REG_DIR = 4'h0;
  localparam logic [3:0] GPP_REG_LAT = 4'h1;
  localparam logic [3:0] GPP_REG_PIN = 4'h2;
  localparam logic [3:0] GPP_REG_ODC = 4'h3;
  localparam logic [3:0] GPP_REG_ANSEL = 4'h4;
  localparam logic [3:0] GPP_REG_CNEN = 4'h5;
  localparam logic [3:0] GPP_REG_CNSTAT = 4'h6;
  localparam logic [3:0] GPP_REG_PU = 4'h7;
  localparam logic [3:0] GPP_REG_PD = 4'h8;
  localparam logic [3:0] GPP_REG_CNCON = 4'h9;

  // Access kinds: base register or one of its aliases
  localparam logic [1:0] GPP_OP_BASE = 2'h0;
  localparam logic [1:0] GPP_OP_CLR = 2'h1;
  localparam logic [1:0] GPP_OP_SET = 2'h2;
  localparam logic [1:0] GPP_OP_INV = 2'h3;

  // Change notice control: module on bit
  localparam int GPP_CNCON_ON_BIT = 15;
  localparam gpp_word_t GPP_CNCON_MASK = 16'h8000;

  // Value after a write of the given kind; only ones in data act on aliases
  function automatic gpp_word_t gpp_apply(input gpp_word_t old_val,
                                          input gpp_word_t data,
                                          input logic [1:0] op);
    gpp_word_t res;
    res = old_val;
    case (op)
      GPP_OP_BASE: res = data;
      GPP_OP_CLR: res = old_val & ~data;
      GPP_OP_SET: res = old_val | data;
      default: res = old_val ^ data;
    endcase
    return res;
  endfunction : gpp_apply

endpackage : gpp_pkg

// *** gpp_port.sv ***
// General purpose port: register store, readback and pin control.
`timescale 1ns/1ps
// Operation
// [R1] Direction one is input, zero drives latch
// [R2] Reset sets all direction bits: inputs
// [R3] Latch reads latch, writes update latch
// [R4] Pin register reads pins, writes go latch
// [R5] Open-drain bit: drive low only, float high
// [R6] Analog select resets to all ones
// [R7] Software clears analog bit before digital use
// [R8] Analog input needs analog and direction set
// [R9] Analog input pins read back as zero
// [R10] Master waits one cycle before port read
// [R11] Change detect works in sleep, raises request
// [R12] Per-pin change interrupt enable bits
// [R13] Status flags change since last pin read
// [R14] Independent per-pin pull-up and pull-down enables
// [R15] Clear, set, invert aliases touch ones only
// [R16] Alias reads undefined; read the base
// [R17] Software keeps pulls off on outputs
// [R18] Capture on read, compare, flag differences
module gpp_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [3:0] acc_sel,
  input wire logic [1:0] acc_op,
  input wire gpp_pkg::gpp_word_t acc_wdata,
  output gpp_pkg::gpp_word_t acc_rdata,
  output logic acc_rvalid,
  input wire gpp_pkg::gpp_word_t pin_in,
  output logic [gpp_pkg::GPP_WIDTH-1:0] pin_out,
  output logic [gpp_pkg::GPP_WIDTH-1:0] pin_oe_n,
  output gpp_pkg::gpp_word_t pull_up_en,
  output gpp_pkg::gpp_word_t pull_down_en,
  output gpp_pkg::gpp_word_t analog_en,
  output logic change_irq
);
  import gpp_pkg::*;

  gpp_word_t direction_reg;
  gpp_word_t output_latch_reg;
  gpp_word_t open_drain_ctl_reg;
  gpp_word_t analog_select_reg;
  gpp_word_t change_irq_enable_reg;
  gpp_word_t pull_up_enable_reg;
  gpp_word_t pull_down_enable_reg;
  gpp_word_t change_notice_control_reg;
  gpp_word_t pin_sample;
  gpp_word_t change_status_reg;
  gpp_word_t read_mux;

  wire gpp_word_t pin_level_reg;
  wire gpp_word_t analog_input;
  wire gpp_word_t next_direction;
  wire gpp_word_t next_latch;
  wire gpp_word_t next_odc;
  wire gpp_word_t next_ansel;
  wire gpp_word_t next_cnen;
  wire gpp_word_t next_pu;
  wire gpp_word_t next_pd;
  wire gpp_word_t next_cncon;
  wire logic wr_dir;
  wire logic wr_lat;
  wire logic wr_odc;
  wire logic wr_ansel;
  wire logic wr_cnen;
  wire logic wr_pu;
  wire logic wr_pd;
  wire logic wr_cncon;
  wire logic pin_read;
  wire logic cn_on;

  // Write strobes per register
  assign wr_dir = acc_wr && acc_sel == GPP_REG_DIR;
  // Pin register writes land in the latch
  assign wr_lat = acc_wr &&
                  (acc_sel == GPP_REG_LAT || acc_sel == GPP_REG_PIN); // [R3] [R4]
  assign wr_odc = acc_wr && acc_sel == GPP_REG_ODC;
  assign wr_ansel = acc_wr && acc_sel == GPP_REG_ANSEL;
  assign wr_cnen = acc_wr && acc_sel == GPP_REG_CNEN;
  assign wr_pu = acc_wr && acc_sel == GPP_REG_PU;
  assign wr_pd = acc_wr && acc_sel == GPP_REG_PD;
  assign wr_cncon = acc_wr && acc_sel == GPP_REG_CNCON;

  // Base writes and alias writes share one helper
  assign next_direction = gpp_apply(direction_reg, acc_wdata, acc_op); // [R15]
  assign next_latch = gpp_apply(output_latch_reg, acc_wdata, acc_op); // [R15]
  assign next_odc = gpp_apply(open_drain_ctl_reg, acc_wdata, acc_op); // [R15]
  assign next_ansel = gpp_apply(analog_select_reg, acc_wdata, acc_op); // [R15]
  assign next_cnen = gpp_apply(change_irq_enable_reg, acc_wdata, acc_op);
  assign next_pu = gpp_apply(pull_up_enable_reg, acc_wdata, acc_op); // [R15]
  assign next_pd = gpp_apply(pull_down_enable_reg, acc_wdata, acc_op);
  // Only the on bit is implemented
  assign next_cncon = gpp_apply(change_notice_control_reg, acc_wdata,
                                acc_op) & GPP_CNCON_MASK;

  // Analog inputs need both bits, software keeps to that
  assign analog_input = analog_select_reg & direction_reg; // [R8]
  assign pin_level_reg = pin_sample & ~analog_input; // [R9]
  // Only a base read of the pin register restarts change tracking
  assign pin_read = acc_rd && acc_sel == GPP_REG_PIN &&
                    acc_op == GPP_OP_BASE; // [R13]
  assign cn_on = change_notice_control_reg[GPP_CNCON_ON_BIT];

  assign pull_up_en = pull_up_enable_reg; // [R14]
  assign pull_down_en = pull_down_enable_reg; // [R14]
  // Digital use needs this bit cleared by software first
  assign analog_en = analog_select_reg; // [R7]

  // Read selection; aliases answer zero, an arbitrary stand-in
  always_comb begin
    read_mux = GPP_ZERO_RST;
    if (acc_op != GPP_OP_BASE) begin
      read_mux = GPP_ZERO_RST; // [R16]
    end else if (acc_sel == GPP_REG_DIR) begin
      read_mux = direction_reg;
    end else if (acc_sel == GPP_REG_LAT) begin
      read_mux = output_latch_reg; // [R3]
    end else if (acc_sel == GPP_REG_PIN) begin
      read_mux = pin_level_reg; // [R4] [R9]
    end else if (acc_sel == GPP_REG_ODC) begin
      read_mux = open_drain_ctl_reg;
    end else if (acc_sel == GPP_REG_ANSEL) begin
      read_mux = analog_select_reg;
    end else if (acc_sel == GPP_REG_CNEN) begin
      read_mux = change_irq_enable_reg;
    end else if (acc_sel == GPP_REG_CNSTAT) begin
      read_mux = change_status_reg; // [R13]
    end else if (acc_sel == GPP_REG_PU) begin
      read_mux = pull_up_enable_reg;
    end else if (acc_sel == GPP_REG_PD) begin
      read_mux = pull_down_enable_reg;
    end else if (acc_sel == GPP_REG_CNCON) begin
      read_mux = change_notice_control_reg;
    end else begin
      read_mux = GPP_ZERO_RST;
    end
  end

  // Pins are sampled once; a read sees levels one cycle old
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sample <= GPP_ZERO_RST;
    end else begin
      pin_sample <= pin_in; // [R10]
    end
  end

  // Reset leaves every pin an input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      direction_reg <= GPP_DIR_RST; // [R2]
    end else if (wr_dir) begin
      direction_reg <= next_direction; // [R1]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_latch_reg <= GPP_ZERO_RST;
    end else if (wr_lat) begin
      output_latch_reg <= next_latch; // [R3] [R4]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_drain_ctl_reg <= GPP_ZERO_RST;
    end else if (wr_odc) begin
      open_drain_ctl_reg <= next_odc; // [R5]
    end
  end

  // Shared pins come up analog until software frees them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_select_reg <= GPP_ANSEL_RST; // [R6]
    end else if (wr_ansel) begin
      analog_select_reg <= next_ansel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_irq_enable_reg <= GPP_ZERO_RST;
    end else if (wr_cnen) begin
      change_irq_enable_reg <= next_cnen; // [R12]
    end
  end

  // Pulls stay under software control even on outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_enable_reg <= GPP_ZERO_RST;
    end else if (wr_pu) begin
      pull_up_enable_reg <= next_pu; // [R14] [R17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_down_enable_reg <= GPP_ZERO_RST;
    end else if (wr_pd) begin
      pull_down_enable_reg <= next_pd; // [R14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_notice_control_reg <= GPP_ZERO_RST;
    end else if (wr_cncon) begin
      change_notice_control_reg <= next_cncon;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rdata <= GPP_ZERO_RST;
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= acc_rd;
      if (acc_rd) begin
        acc_rdata <= read_mux;
      end
    end
  end

  gpp_pin_drive u_drive (
    .direction(direction_reg),
    .latch(output_latch_reg),
    .open_drain(open_drain_ctl_reg),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

  gpp_change_detect u_change (
    .clk(clk),
    .rst_n(rst_n),
    .pin_now(pin_sample),
    .pin_raw(pin_in),
    .capture(pin_read),
    .enable(change_irq_enable_reg),
    .module_on(cn_on),
    .status(change_status_reg),
    .change_irq(change_irq)
  );

endmodule : gpp_port

// *** gpp_port_properties.sv ***
// Port-level assertions for the general purpose port.
`timescale 1ns/1ps
module gpp_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [3:0] acc_sel,
  input wire logic [1:0] acc_op,
  input wire gpp_pkg::gpp_word_t acc_wdata,
  input wire gpp_pkg::gpp_word_t acc_rdata,
  input wire logic acc_rvalid,
  input wire logic [15:0] pin_oe_n,
  input wire gpp_pkg::gpp_word_t pull_up_en,
  input wire gpp_pkg::gpp_word_t pull_down_en,
  input wire gpp_pkg::gpp_word_t analog_en
);
  import gpp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pu_set_s;
    acc_wr && acc_sel == GPP_REG_PU && acc_op == GPP_OP_SET;
  endsequence
  sequence pd_clr_s;
    acc_wr && acc_sel == GPP_REG_PD && acc_op == GPP_OP_CLR;
  endsequence
  read_answer_a: assert property (acc_rd |=> acc_rvalid)
    else $error("read not answered");
  rdata_hold_a: assert property (
    !acc_rd |=> $stable(acc_rdata) && !acc_rvalid)
    else $error("read data moved without read");
  reset_dir_a: assert property (
    $rose(rst_n) |-> pin_oe_n == GPP_DIR_RST)
    else $error("pins not inputs after reset");
  reset_ansel_a: assert property (
    $rose(rst_n) |-> analog_en == GPP_ANSEL_RST)
    else $error("analog select reset wrong");
  pu_set_a: assert property (pu_set_s |=>
    pull_up_en == ($past(pull_up_en) | $past(acc_wdata)))
    else $error("pull-up set alias wrong");
  pd_clr_a: assert property (pd_clr_s |=>
    pull_down_en == ($past(pull_down_en) & ~$past(acc_wdata)))
    else $error("pull-down clear alias wrong");
  pu_hold_a: assert property (
    !(acc_wr && acc_sel == GPP_REG_PU) |=> $stable(pull_up_en))
    else $error("pull-up changed without write");
  alias_read_a: assert property (
    acc_rd && acc_op != GPP_OP_BASE |=> acc_rdata == GPP_ZERO_RST)
    else $error("alias read not zero");
endmodule : gpp_port_checker
bind gpp_port gpp_port_checker u_chk (.clk, .rst_n, .acc_wr, .acc_rd,
  .acc_sel, .acc_op, .acc_wdata, .acc_rdata, .acc_rvalid, .pin_oe_n,
  .pull_up_en, .pull_down_en, .analog_en);

// *** gpp_port_tb.sv ***
// Self-checking testbench for the general purpose port.
`timescale 1ns/1ps
module gpp_port_tb;
  import gpp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, acc_wr = 1'b0, acc_rd = 1'b0;
  logic [3:0] acc_sel = 4'h0;
  logic [1:0] acc_op = 2'h0;
  gpp_word_t acc_wdata = 16'h0000, ext_en = 16'h0000, ext_val = 16'h0000;
  gpp_word_t acc_rdata, pull_up_en, pull_down_en, analog_en, pad;
  logic [15:0] pin_out, pin_oe_n;
  logic acc_rvalid, change_irq;
  int errors = 0, checks = 0;
  gpp_port dut (.clk, .rst_n, .acc_wr, .acc_rd, .acc_sel, .acc_op, .acc_wdata,
    .acc_rdata, .acc_rvalid, .pin_in(pad), .pin_out, .pin_oe_n, .pull_up_en,
    .pull_down_en, .analog_en, .change_irq);
  gpp_pad_model pads (.pin_out, .pin_oe_n, .pull_up_en, .pull_down_en,
    .ext_en, .ext_val, .pad);
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input gpp_word_t got, input gpp_word_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // Strobe for one cycle, then an idle cycle before any following read
  task automatic wr(input logic [3:0] s, input logic [1:0] o, gpp_word_t d);
    step;
    acc_wr = 1'b1;
    acc_sel = s;
    acc_op = o;
    acc_wdata = d;
    step;
    acc_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [1:0] o, gpp_word_t e);
    step;
    acc_rd = 1'b1;
    acc_sel = s;
    acc_op = o;
    step;
    acc_rd = 1'b0;
    chk({15'h0000, acc_rvalid}, 16'h0001);
    chk(acc_rdata, e);
  endtask : rd
  task automatic t_io;
    wr(GPP_REG_ANSEL, GPP_OP_BASE, 16'h0000);
    wr(GPP_REG_LAT, GPP_OP_BASE, 16'h00a5);
    wr(GPP_REG_DIR, GPP_OP_BASE, 16'hff00);
    chk(pin_oe_n, 16'hff00);
    chk(pin_out, 16'h00a5);
    ext_en = 16'hff00;
    ext_val = 16'h1234;
    rd(GPP_REG_DIR, GPP_OP_BASE, 16'hff00);
    rd(GPP_REG_LAT, GPP_OP_BASE, 16'h00a5);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h12a5);
    wr(GPP_REG_PIN, GPP_OP_BASE, 16'h0f0f);
    rd(GPP_REG_LAT, GPP_OP_BASE, 16'h0f0f);
    $display("test io done");
  endtask : t_io
  task automatic t_alias;
    gpp_word_t v;
    v = 16'h0f0f;
    for (int i = 1; i < 4; i++) begin
      wr(GPP_REG_LAT, 2'(i), 16'h0ff0);
      v = (i == 1) ? v & ~16'h0ff0 : (i == 2) ? v | 16'h0ff0 : v ^ 16'h0ff0;
      rd(GPP_REG_LAT, GPP_OP_BASE, v);
      rd(GPP_REG_LAT, 2'(i), GPP_ZERO_RST);
    end
    $display("test alias done");
  endtask : t_alias
  task automatic t_od;
    wr(GPP_REG_ODC, GPP_OP_BASE, 16'h0003);
    chk(pin_oe_n, 16'hff03);
    rd(GPP_REG_ODC, GPP_OP_BASE, 16'h0003);
    wr(GPP_REG_LAT, GPP_OP_CLR, 16'h0001);
    chk(pin_oe_n, 16'hff02);
    chk(pin_out, 16'h000c);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h120e);
    wr(GPP_REG_ODC, GPP_OP_BASE, 16'h0000);
    wr(GPP_REG_ANSEL, GPP_OP_INV, 16'h1000);
    chk(analog_en, 16'h1000);
    rd(GPP_REG_ANSEL, GPP_OP_BASE, 16'h1000);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h020e);
    wr(GPP_REG_ANSEL, GPP_OP_INV, 16'h1000);
    $display("test drive done");
  endtask : t_od
  task automatic t_pulls;
    ext_en = 16'h0000;
    wr(GPP_REG_PU, GPP_OP_BASE, 16'h0f00);
    wr(GPP_REG_PD, GPP_OP_BASE, 16'hf000);
    wr(GPP_REG_PU, GPP_OP_SET, 16'h3000);
    wr(GPP_REG_PD, GPP_OP_CLR, 16'h3000);
    chk(pull_up_en, 16'h3f00);
    chk(pull_down_en, 16'hc000);
    rd(GPP_REG_PU, GPP_OP_BASE, 16'h3f00);
    rd(GPP_REG_PD, GPP_OP_BASE, 16'hc000);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h3f0e);
    wr(GPP_REG_PU, GPP_OP_BASE, 16'h0000);
    wr(GPP_REG_PD, GPP_OP_BASE, 16'h0000);
    $display("test pulls done");
  endtask : t_pulls
  task automatic t_change;
    ext_en = 16'hff00;
    wr(GPP_REG_CNCON, GPP_OP_BASE, 16'h8000);
    wr(GPP_REG_CNEN, GPP_OP_BASE, 16'h0100);
    rd(GPP_REG_CNCON, GPP_OP_BASE, 16'h8000);
    rd(GPP_REG_CNEN, GPP_OP_BASE, 16'h0100);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h120e);
    rd(GPP_REG_CNSTAT, GPP_OP_BASE, 16'h0000);
    ext_val = 16'h1734;
    step;
    step;
    chk({15'h0000, change_irq}, 16'h0001);
    rd(GPP_REG_CNSTAT, GPP_OP_BASE, 16'h0500);
    rd(GPP_REG_PIN, GPP_OP_BASE, 16'h170e);
    rd(GPP_REG_CNSTAT, GPP_OP_BASE, 16'h0000);
    ext_val = 16'h1334;
    step;
    step;
    chk({15'h0000, change_irq}, 16'h0000);
    // No clock edge before the check: the path a stopped clock relies on
    ext_val = 16'h1234;
    #1;
    chk({15'h0000, change_irq}, 16'h0001);
    $display("test change done");
  endtask : t_change
  task automatic t_reset;
    step;
    rst_n = 1'b0;
    #1;
    chk(pin_oe_n, GPP_DIR_RST);
    chk(analog_en, GPP_ANSEL_RST);
    step;
    rst_n = 1'b1;
    rd(GPP_REG_DIR, GPP_OP_BASE, GPP_DIR_RST);
    rd(GPP_REG_LAT, GPP_OP_BASE, GPP_ZERO_RST);
    $display("test second reset done");
  endtask : t_reset
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(pin_oe_n, GPP_DIR_RST);
    chk(analog_en, GPP_ANSEL_RST);
    $display("test reset done");
    t_io;
    t_alias;
    t_od;
    t_pulls;
    t_change;
    t_reset;
    report_and_stop;
  end
  // Far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule : gpp_port_tb
